// ===== rtl/mmd_pkg.sv
// Purpose: Constants and types for the on-chip memory map decoder
// Assumes: 16-bit CPU addresses, 8-bit data, one 20 MHz clock
// Notes:   Mode strap coding and settle count are local choices
//
// What this block does
// - A 2K byte RAM is decoded and software can move it to any 4K boundary through the RAM page field.
// - Out of reset, before any remap write, RAM starts at address 0x0080.
// - Once the register block and RAM sit on different pages, RAM fills 2048 bytes of the direct address range.
// - In the software stop state the clocks are halted and RAM contents stay unchanged until wake.
// - The 48K byte program ROM is decoded only while the ROM present bit is one.
// - In expanded mode ROM sits at 0x4000-0xFFFF when the placement bit is one, else at 0x0000-0xBFFF.
// - In bootstrap mode the bootloader ROM is enabled at 0xBE40 to 0xBFFF.
// - In bootstrap mode the reset vector fetch is served from the bootloader ROM.
// - In single chip and expanded modes the bootloader ROM is out of the map.
// - The 128-byte register block sits at 0x0000-0x007F by default and moves to offset 0x00 of the chosen 4K page.
// - When RAM and registers share a page, RAM starts at offset 0x080 and its first 128 bytes move to 0x800-0x87F.
// - The mapping register holds the RAM page in its upper nibble and the register page in its lower nibble.
// - Test mode clears the ROM present bit; single chip mode forces the placement bit to one after reset.

package mmd_pkg;

	// Operating modes latched at reset
	typedef enum logic [1:0] {
		MMD_MODE_BOOT,
		MMD_MODE_SINGLE,
		MMD_MODE_TEST,
		MMD_MODE_EXPANDED
	} mmd_mode_type;

	// Strap codes on {mode_b, mode_a}
	localparam logic [1:0]  MMD_STRAP_BOOT      = 2'h0;
	localparam logic [1:0]  MMD_STRAP_TEST      = 2'h1;
	localparam logic [1:0]  MMD_STRAP_SINGLE    = 2'h2;
	localparam logic [1:0]  MMD_STRAP_EXPANDED  = 2'h3;

	// Cycles after reset release before straps are taken
	localparam logic [1:0]  MMD_STRAP_SETTLE    = 2'h2;

	// Mapping register
	localparam logic [7:0]  MMD_MAP_RESET       = 8'h00;
	localparam int          MMD_MAP_RAM_HI      = 7;
	localparam int          MMD_MAP_RAM_LO      = 4;
	localparam int          MMD_MAP_REG_HI      = 3;
	localparam int          MMD_MAP_REG_LO      = 0;

	// Widths
	localparam int          MMD_ADDR_W          = 16;
	localparam int          MMD_DATA_W          = 8;
	localparam int          MMD_RAM_AW          = 11;
	localparam int          MMD_RAM_DEPTH       = 2048;
	localparam int          MMD_REG_AW          = 7;
	localparam int          MMD_BOOT_AW         = 9;

	// Page offsets within a 4K page
	localparam logic [11:0] MMD_RAM_SHARED_LO   = 12'h080;
	localparam logic [11:0] MMD_RAM_SHARED_HI   = 12'h7ff;
	localparam logic [11:0] MMD_RAM_MOVED_LO    = 12'h800;
	localparam logic [11:0] MMD_RAM_MOVED_HI    = 12'h87f;
	localparam logic [4:0]  MMD_REG_PAGE_TOP    = 5'h00;

	// Program ROM windows
	localparam logic [15:0] MMD_ROM_HIGH_LO     = 16'h4000;
	localparam logic [15:0] MMD_ROM_LOW_HI      = 16'hbfff;

	// Bootloader ROM window, and the reset vector pair and its row in the 512 byte block
	localparam logic [15:0] MMD_BOOT_LO         = 16'hbe40;
	localparam logic [15:0] MMD_BOOT_HI         = 16'hbfff;
	localparam logic [14:0] MMD_RESET_VEC_PAIR  = 15'h7fff;
	localparam logic [7:0]  MMD_BOOT_VEC_ROW    = 8'hff;

endpackage

// ===== rtl/mmd_ram.sv
// Purpose: 2K x 8 static RAM with registered read data
// Assumes: Single clock, enable gates all activity
// Notes:   Contents are never reset

`timescale 1ns/100ps

module mmd_ram (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	// Access port
	input  wire logic                          en,
	input  wire logic                          we,
	input  wire logic [mmd_pkg::MMD_RAM_AW-1:0] addr,
	input  wire logic [mmd_pkg::MMD_DATA_W-1:0] wdata,
	output logic      [mmd_pkg::MMD_DATA_W-1:0] rdata
);
	import mmd_pkg::*;

	logic [MMD_DATA_W-1:0] mem [MMD_RAM_DEPTH];

	// Array holds its contents whenever en is low
	always_ff @(posedge ref_clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (en && !we) begin
			rdata <= mem[addr];
		end
	end

endmodule

// ===== rtl/mmd_decoder.sv
// Purpose: Memory map decoder for RAM, register block, program ROM and bootloader ROM
// Assumes: CPU request is valid for one cycle; answers come one cycle later
// Notes:   Mode straps and wake pin are synchronised; config bits are same-domain

`timescale 1ns/100ps

module mmd_decoder (
	// Clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           nrst,
	// Mode strap and wake pins
	input  wire logic                           mode_b_pin,
	input  wire logic                           mode_a_pin,
	input  wire logic                           wake_pin,
	// Configuration bits
	input  wire logic                           cfg_rom_present_bit,
	input  wire logic                           cfg_rom_placement_bit,
	// Mapping register write
	input  wire logic                           map_wr,
	input  wire logic [mmd_pkg::MMD_DATA_W-1:0] map_wdata,
	// Stop request from software
	input  wire logic                           stop_req,
	// CPU bus
	input  wire logic                           cpu_valid,
	input  wire logic                           cpu_write,
	input  wire logic                           cpu_vector,
	input  wire logic [mmd_pkg::MMD_ADDR_W-1:0] cpu_addr,
	input  wire logic [mmd_pkg::MMD_DATA_W-1:0] cpu_wdata,
	// Status
	output logic                                mode_ready,
	output mmd_pkg::mmd_mode_type               op_mode,
	output logic                                clk_run,
	output logic      [mmd_pkg::MMD_DATA_W-1:0] map_value,
	output logic                                rom_present_bit,
	output logic                                rom_placement_bit,
	// Decode answer
	output logic                                dec_valid,
	output logic                                sel_reg,
	output logic                                sel_ram,
	output logic                                sel_boot,
	output logic                                sel_rom,
	output logic                                sel_ext,
	output logic      [mmd_pkg::MMD_REG_AW-1:0]  reg_offset,
	output logic      [mmd_pkg::MMD_RAM_AW-1:0]  ram_index,
	output logic      [mmd_pkg::MMD_ADDR_W-1:0] rom_offset,
	output logic      [mmd_pkg::MMD_BOOT_AW-1:0] boot_offset,
	output logic      [mmd_pkg::MMD_DATA_W-1:0] ram_rdata
);
	import mmd_pkg::*;

	typedef struct packed {
		logic [1:0]            strap_s1;
		logic [1:0]            strap_s2;
		logic                  wake_s1;
		logic                  wake_s2;
		logic [1:0]            settle;
		mmd_mode_type          mode;
		logic                  mode_valid;
		logic                  rom_present;
		logic                  rom_placement;
		logic [MMD_DATA_W-1:0] map;
		logic                  stopped;
		logic                  dec_valid;
		logic                  sel_reg;
		logic                  sel_ram;
		logic                  sel_boot;
		logic                  sel_rom;
		logic                  sel_ext;
		logic [MMD_REG_AW-1:0]  reg_offset;
		logic [MMD_RAM_AW-1:0]  ram_index;
		logic [MMD_ADDR_W-1:0] rom_offset;
		logic [MMD_BOOT_AW-1:0] boot_offset;
	} mmd_state_type;

	localparam mmd_state_type MMD_STATE_RESET = '{
		strap_s1:      2'h0,
		strap_s2:      2'h0,
		wake_s1:       1'b0,
		wake_s2:       1'b0,
		settle:        2'h0,
		mode:          MMD_MODE_SINGLE,
		mode_valid:    1'b0,
		rom_present:   1'b0,
		rom_placement: 1'b0,
		map:           MMD_MAP_RESET,
		stopped:       1'b0,
		dec_valid:     1'b0,
		sel_reg:       1'b0,
		sel_ram:       1'b0,
		sel_boot:      1'b0,
		sel_rom:       1'b0,
		sel_ext:       1'b0,
		reg_offset:    '0,
		ram_index:     '0,
		rom_offset:    '0,
		boot_offset:   '0
	};

	mmd_state_type state_q;
	mmd_state_type state_d;

	// Decode terms
	logic [3:0]            ram_page;
	logic [3:0]            reg_page;
	logic [3:0]            addr_page;
	logic [11:0]           page_off;
	logic                  pages_shared;
	logic                  reg_hit;
	logic                  ram_hit;
	logic [MMD_RAM_AW-1:0]  ram_idx;
	logic                  boot_mode;
	logic                  vec_hit;
	logic                  boot_hit;
	logic [MMD_BOOT_AW-1:0] boot_idx;
	logic                  rom_hit;
	logic [MMD_ADDR_W-1:0] rom_idx;
	logic                  ext_mode;
	logic                  take;
	logic                  ram_en;
	mmd_mode_type          strap_mode;

	assign ram_page  = state_q.map[MMD_MAP_RAM_HI:MMD_MAP_RAM_LO];
	assign reg_page  = state_q.map[MMD_MAP_REG_HI:MMD_MAP_REG_LO];
	assign addr_page = cpu_addr[15:12];
	assign page_off  = cpu_addr[11:0];
	assign boot_mode = (state_q.mode == MMD_MODE_BOOT);
	assign ext_mode  = (state_q.mode == MMD_MODE_EXPANDED) || (state_q.mode == MMD_MODE_TEST);

	// Accesses are taken only once the mode is known and while running
	assign take   = cpu_valid && state_q.mode_valid && !state_q.stopped;

	// Register block at offset 0x00-0x7F of its page
	always_comb begin
		reg_hit = (addr_page == reg_page) && (page_off[11:7] == MMD_REG_PAGE_TOP);
	end

	// RAM placement, with relocation when sharing the register page
	always_comb begin
		pages_shared = (ram_page == reg_page);
		ram_hit      = 1'b0;
		ram_idx      = page_off[MMD_RAM_AW-1:0];
		if (addr_page == ram_page) begin
			if (pages_shared) begin
				if ((page_off >= MMD_RAM_SHARED_LO) && (page_off <= MMD_RAM_SHARED_HI)) begin
					ram_hit = 1'b1;
					ram_idx = page_off[MMD_RAM_AW-1:0];
				end else if ((page_off >= MMD_RAM_MOVED_LO) && (page_off <= MMD_RAM_MOVED_HI)) begin
					ram_hit = 1'b1;
					ram_idx = {4'h0, page_off[6:0]};
				end
			end else begin
				ram_hit = !page_off[11];
				ram_idx = page_off[MMD_RAM_AW-1:0];
			end
		end
	end

	// Bootloader ROM and the reset vector in bootstrap mode only
	always_comb begin
		vec_hit  = boot_mode && cpu_vector && (cpu_addr[15:1] == MMD_RESET_VEC_PAIR);
		boot_hit = boot_mode && (cpu_addr >= MMD_BOOT_LO) && (cpu_addr <= MMD_BOOT_HI);
		boot_idx = cpu_addr[MMD_BOOT_AW-1:0];
		if (vec_hit) begin
			boot_idx = {MMD_BOOT_VEC_ROW, cpu_addr[0]};
		end
	end

	// Program ROM presence and placement
	always_comb begin
		rom_hit = 1'b0;
		rom_idx = cpu_addr;
		if (state_q.rom_present) begin
			if (state_q.rom_placement) begin
				rom_hit = (cpu_addr >= MMD_ROM_HIGH_LO);
				rom_idx = cpu_addr - MMD_ROM_HIGH_LO;
			end else begin
				rom_hit = (cpu_addr <= MMD_ROM_LOW_HI);
				rom_idx = cpu_addr;
			end
		end
	end

	// Strap coding
	always_comb begin
		unique case (state_q.strap_s2)
			MMD_STRAP_BOOT:     strap_mode = MMD_MODE_BOOT;
			MMD_STRAP_TEST:     strap_mode = MMD_MODE_TEST;
			MMD_STRAP_SINGLE:   strap_mode = MMD_MODE_SINGLE;
			MMD_STRAP_EXPANDED: strap_mode = MMD_MODE_EXPANDED;
		endcase
	end

	// RAM access only when it wins the priority and the clocks run
	// Vector fetch and register block shadow the RAM
	assign ram_en = take && !vec_hit && !reg_hit && ram_hit;

	always_comb begin
		state_d = state_q;

		// Synchronisers
		state_d.strap_s1 = {mode_b_pin, mode_a_pin};
		state_d.strap_s2 = state_q.strap_s1;
		state_d.wake_s1  = wake_pin;
		state_d.wake_s2  = state_q.wake_s1;

		// Mode and configuration latched once after reset release
		if (!state_q.mode_valid) begin
			if (state_q.settle == MMD_STRAP_SETTLE) begin
				state_d.mode_valid    = 1'b1;
				state_d.mode          = strap_mode;
				state_d.rom_present   = (strap_mode == MMD_MODE_TEST) ? 1'b0 : cfg_rom_present_bit;
				state_d.rom_placement = cfg_rom_placement_bit;
				if ((strap_mode == MMD_MODE_SINGLE) || (strap_mode == MMD_MODE_BOOT)) begin
					state_d.rom_placement = 1'b1;
				end
			end else begin
				state_d.settle = state_q.settle + 2'h1;
			end
		end

		// Stop state: entered by software, left on wake
		if (state_q.stopped) begin
			if (state_q.wake_s2) begin
				state_d.stopped = 1'b0;
			end
		end else if (stop_req && state_q.mode_valid) begin
			state_d.stopped = 1'b1;
		end

		// Mapping register write
		if (map_wr && state_q.mode_valid && !state_q.stopped) begin
			state_d.map = map_wdata;
		end

		// Decode answer, one cycle after the request
		state_d.dec_valid   = take;
		state_d.sel_reg     = 1'b0;
		state_d.sel_ram     = 1'b0;
		state_d.sel_boot    = 1'b0;
		state_d.sel_rom     = 1'b0;
		state_d.sel_ext     = 1'b0;
		state_d.reg_offset  = cpu_addr[MMD_REG_AW-1:0];
		state_d.ram_index   = ram_idx;
		state_d.rom_offset  = rom_idx;
		state_d.boot_offset = boot_idx;
		if (take) begin
			if (vec_hit) begin
				state_d.sel_boot = 1'b1;
			end else if (reg_hit) begin
				state_d.sel_reg = 1'b1;
			end else if (ram_hit) begin
				state_d.sel_ram = 1'b1;
			end else if (boot_hit) begin
				state_d.sel_boot = 1'b1;
			end else if (rom_hit) begin
				state_d.sel_rom = 1'b1;
			end else begin
				state_d.sel_ext = ext_mode;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= MMD_STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// On-chip RAM; held untouched while stopped
	mmd_ram u_ram (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.en      (ram_en),
		.we      (cpu_write),
		.addr    (ram_idx),
		.wdata   (cpu_wdata),
		.rdata   (ram_rdata)
	);

	// Outputs
	assign mode_ready        = state_q.mode_valid;
	assign op_mode           = state_q.mode;
	assign clk_run           = !state_q.stopped;
	assign map_value         = state_q.map;
	assign rom_present_bit   = state_q.rom_present;
	assign rom_placement_bit = state_q.rom_placement;
	assign dec_valid         = state_q.dec_valid;
	assign sel_reg           = state_q.sel_reg;
	assign sel_ram           = state_q.sel_ram;
	assign sel_boot          = state_q.sel_boot;
	assign sel_rom           = state_q.sel_rom;
	assign sel_ext           = state_q.sel_ext;
	assign reg_offset        = state_q.reg_offset;
	assign ram_index         = state_q.ram_index;
	assign rom_offset        = state_q.rom_offset;
	assign boot_offset       = state_q.boot_offset;

endmodule

// ===== bench/mmd_decoder_properties.sv
// Purpose: Port assertions for the memory map decoder
// Assumes: Mapping register is not written in the cycle of a request
// Notes:   Bound from the testbench top file
`timescale 1ns/100ps
module mmd_decoder_properties
	import mmd_pkg::*;
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              nrst,
	// Requests
	input wire logic              stop_req,
	input wire logic              cpu_valid,
	input wire logic              cpu_vector,
	input wire logic [15:0]       cpu_addr,
	// Status
	input wire logic              mode_ready,
	input mmd_pkg::mmd_mode_type  op_mode,
	input wire logic              clk_run,
	input wire logic [7:0]        map_value,
	input wire logic              rom_present_bit,
	input wire logic              rom_placement_bit,
	// Decode answer
	input wire logic              dec_valid,
	input wire logic              sel_reg,
	input wire logic              sel_ram,
	input wire logic              sel_boot,
	input wire logic              sel_rom,
	input wire logic              sel_ext,
	input wire logic [6:0]        reg_offset,
	input wire logic [10:0]       ram_index,
	input wire logic [8:0]        boot_offset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic       live;
	logic       take;
	logic [3:0] pg;
	assign live = cpu_valid && mode_ready && clk_run;
	assign take = live && !cpu_vector;
	assign pg = cpu_addr[15:12];
	AST_REG_PAGE: assert property (take && pg == map_value[3:0] && cpu_addr[11:7] == 5'h00
		|=> sel_reg && reg_offset == $past(cpu_addr[6:0])) else $error("register block decode wrong");
	AST_RAM_MOVED: assert property (take && pg == map_value[7:4] && pg == map_value[3:0]
		&& cpu_addr[11:7] == 5'h10 |=> sel_ram && ram_index == {4'h0, $past(cpu_addr[6:0])})
		else $error("moved RAM bytes decode wrong");
	AST_RAM_PAGE: assert property (take && pg == map_value[7:4] && pg != map_value[3:0] && !cpu_addr[11]
		|=> sel_ram && ram_index == $past(cpu_addr[10:0])) else $error("RAM page decode wrong");
	AST_BOOT_WIN: assert property (take && op_mode == MMD_MODE_BOOT && cpu_addr >= 16'hbe40
		&& map_value[7:4] != 4'hb && map_value[3:0] != 4'hb && cpu_addr <= 16'hbfff
		|=> sel_boot && boot_offset == $past(cpu_addr[8:0])) else $error("boot window decode wrong");
	AST_VECTOR: assert property (live && cpu_vector && op_mode == MMD_MODE_BOOT && cpu_addr[15:1] == 15'h7fff
		|=> sel_boot && boot_offset == {8'hff, $past(cpu_addr[0])}) else $error("vector not from boot ROM");
	AST_NO_BOOT: assert property (op_mode != MMD_MODE_BOOT |-> !sel_boot) else $error("boot ROM in normal mode");
	AST_ROM_GONE: assert property (!rom_present_bit |-> !sel_rom) else $error("absent ROM selected");
	AST_TEST_ROM: assert property (mode_ready && op_mode == MMD_MODE_TEST |-> !rom_present_bit)
		else $error("test mode kept ROM");
	AST_SINGLE_HI: assert property (mode_ready && op_mode == MMD_MODE_SINGLE |-> rom_placement_bit)
		else $error("single chip placement not forced");
	AST_STOP: assert property (stop_req && mode_ready && clk_run |=> !clk_run) else $error("stop not taken");
	AST_STOP_QUIET: assert property (!clk_run |=> !dec_valid) else $error("answer while stopped");
	AST_ONE_SEL: assert property (dec_valid |-> $onehot0({sel_reg, sel_ram, sel_boot, sel_rom, sel_ext}))
		else $error("several selects at once");
endmodule

// ===== bench/mmd_cpu_model.sv
// Purpose: CPU core model issuing single byte requests
// Assumes: Requests launch at the falling edge and stand one cycle
// Notes:   Idle bus lines show the inverse of the last value
`timescale 1ns/100ps
module mmd_cpu_model (
	// Clock
	input wire logic    ref_clk,
	// CPU bus
	output logic        cpu_valid,
	output logic        cpu_write,
	output logic        cpu_vector,
	output logic [15:0] cpu_addr,
	output logic [7:0]  cpu_wdata
);
	initial begin
		{cpu_valid, cpu_write, cpu_vector, cpu_addr, cpu_wdata} = 27'h0;
	end
	task automatic access(input logic [15:0] a, input logic w, input logic v, input logic [7:0] d);
		@(negedge ref_clk);
		{cpu_valid, cpu_write, cpu_vector, cpu_addr, cpu_wdata} = {1'b1, w, v, a, d};
		@(negedge ref_clk);
		{cpu_valid, cpu_write, cpu_vector, cpu_addr, cpu_wdata} = {1'b0, ~w, ~v, ~a, ~d};
	endtask
endmodule

// ===== bench/mmd_decoder_tb.sv
// Purpose: Self-checking bench for the memory map decoder
// Assumes: Inputs change at the falling edge of ref_clk
// Notes:   Each mode is entered through its own reset
`timescale 1ns/100ps
module mmd_decoder_tb;
	import mmd_pkg::*;
	localparam logic [5:0] REG = 6'h30, RAM = 6'h28, BOOT = 6'h24, ROM = 6'h22, EXT = 6'h21, NONE = 6'h20;
	logic         ref_clk, nrst, mode_b_pin, mode_a_pin, wake_pin, cfg_rom_present_bit, cfg_rom_placement_bit;
	logic         map_wr, stop_req, cpu_valid, cpu_write, cpu_vector, mode_ready, clk_run;
	logic         rom_present_bit, rom_placement_bit, dec_valid, sel_reg, sel_ram, sel_boot, sel_rom, sel_ext;
	logic [7:0]   map_wdata, cpu_wdata, map_value, ram_rdata;
	logic [15:0]  cpu_addr, rom_offset;
	logic [6:0]   reg_offset;
	logic [10:0]  ram_index;
	logic [8:0]   boot_offset;
	mmd_mode_type op_mode;
	int           n_mismatch, compares;
	mmd_decoder mmd_decoder_i (.ref_clk, .nrst, .mode_b_pin, .mode_a_pin, .wake_pin, .cfg_rom_present_bit,
		.cfg_rom_placement_bit, .map_wr, .map_wdata, .stop_req, .cpu_valid, .cpu_write, .cpu_vector, .cpu_addr,
		.cpu_wdata, .mode_ready, .op_mode, .clk_run, .map_value, .rom_present_bit, .rom_placement_bit, .dec_valid,
		.sel_reg, .sel_ram, .sel_boot, .sel_rom, .sel_ext, .reg_offset, .ram_index, .rom_offset, .boot_offset,
		.ram_rdata);
	mmd_cpu_model mmd_cpu_model_i (.ref_clk, .cpu_valid, .cpu_write, .cpu_vector, .cpu_addr, .cpu_wdata);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic rst(input logic [1:0] strap, input logic rp, input logic pl);
		int n = 0;
		@(negedge ref_clk);
		{nrst, mode_b_pin, mode_a_pin, cfg_rom_present_bit, cfg_rom_placement_bit} = {1'b0, strap, rp, pl};
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		while (mode_ready !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 10) begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic dec(input logic [15:0] a, input logic [5:0] es, input logic [15:0] ei, input logic v = 1'b0);
		logic [15:0] gi;
		mmd_cpu_model_i.access(a, 1'b0, v, 8'h00);
		gi = es[4] ? {9'h0, reg_offset} : es[3] ? {5'h0, ram_index} : es[2] ? {7'h0, boot_offset} :
			es[1] ? rom_offset : 16'h0;
		chk({10'h0, dec_valid, sel_reg, sel_ram, sel_boot, sel_rom, sel_ext}, {10'h0, es});
		chk(gi, ei);
	endtask
	task automatic wr_map(input logic [7:0] d);
		@(negedge ref_clk);
		{map_wr, map_wdata} = {1'b1, d};
		@(negedge ref_clk);
		{map_wr, map_wdata} = {1'b0, ~d};
		chk({8'h0, map_value}, {8'h0, d});
	endtask
	task automatic t_exp_hi;
		rst(2'h3, 1'b1, 1'b1);
		chk({14'h0, op_mode}, 16'h0003);
		chk({8'h0, map_value}, 16'h0000);
		dec(16'h0010, REG, 16'h0010);
		dec(16'h0080, RAM, 16'h0080);
		dec(16'h07ff, RAM, 16'h07ff);
		dec(16'h0800, RAM, 16'h0000);
		dec(16'h087f, RAM, 16'h007f);
		dec(16'h0880, EXT, 16'h0000);
		dec(16'h3fff, EXT, 16'h0000);
		dec(16'h4000, ROM, 16'h0000);
		dec(16'hbe40, ROM, 16'h7e40);
		$display("test exp_hi done");
	endtask
	task automatic t_remap;
		wr_map(8'h21);
		dec(16'h1005, REG, 16'h0005);
		dec(16'h2000, RAM, 16'h0000);
		dec(16'h27ff, RAM, 16'h07ff);
		dec(16'h2800, EXT, 16'h0000);
		dec(16'h0010, EXT, 16'h0000);
		wr_map(8'h01);
		dec(16'h0000, RAM, 16'h0000);
		dec(16'h00ff, RAM, 16'h00ff);
		dec(16'h1000, REG, 16'h0000);
		mmd_cpu_model_i.access(16'h00c3, 1'b1, 1'b0, 8'h3c);
		dec(16'h00c3, RAM, 16'h00c3);
		chk({8'h0, ram_rdata}, 16'h003c);
		$display("test remap done");
	endtask
	task automatic t_stop;
		int n = 0;
		wr_map(8'h00);
		mmd_cpu_model_i.access(16'h0100, 1'b1, 1'b0, 8'h5a);
		@(negedge ref_clk);
		stop_req = 1'b1;
		@(negedge ref_clk);
		stop_req = 1'b0;
		chk({15'h0, clk_run}, 16'h0000);
		dec(16'h0100, 6'h00, 16'h0000);
		mmd_cpu_model_i.access(16'h0100, 1'b1, 1'b0, 8'ha5);
		@(negedge ref_clk);
		wake_pin = 1'b1;
		while (clk_run !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		wake_pin = 1'b0;
		if (n == 8) begin
			n_mismatch++;
			close_out();
		end
		chk(16'(n), 16'h0003);
		dec(16'h0100, RAM, 16'h0100);
		chk({8'h0, ram_rdata}, 16'h005a);
		$display("test stop done");
	endtask
	task automatic t_modes;
		rst(2'h3, 1'b1, 1'b0);
		dec(16'h0010, REG, 16'h0010);
		dec(16'h0850, RAM, 16'h0050);
		dec(16'h0900, ROM, 16'h0900);
		dec(16'hc000, EXT, 16'h0000);
		rst(2'h1, 1'b1, 1'b1);
		chk({15'h0, rom_present_bit}, 16'h0000);
		dec(16'h4000, EXT, 16'h0000);
		rst(2'h2, 1'b1, 1'b0);
		chk({15'h0, rom_placement_bit}, 16'h0001);
		dec(16'h4000, ROM, 16'h0000);
		dec(16'h1000, NONE, 16'h0000);
		rst(2'h2, 1'b0, 1'b1);
		dec(16'hffff, NONE, 16'h0000);
		$display("test modes done");
	endtask
	task automatic t_boot;
		rst(2'h0, 1'b1, 1'b0);
		chk({14'h0, op_mode}, 16'h0000);
		dec(16'hbe40, BOOT, 16'h0040);
		dec(16'hbfff, BOOT, 16'h01ff);
		dec(16'hbe3f, ROM, 16'h7e3f);
		dec(16'hfffe, BOOT, 16'h01fe, 1'b1);
		dec(16'hffff, BOOT, 16'h01ff, 1'b1);
		dec(16'hfffe, ROM, 16'hbffe);
		$display("test boot done");
	endtask
	initial begin
		{nrst, mode_b_pin, mode_a_pin, wake_pin, cfg_rom_present_bit, cfg_rom_placement_bit, map_wr, stop_req} = 8'h00;
		map_wdata = 8'h00;
		n_mismatch = 0;
		compares = 0;
		t_exp_hi();
		t_remap();
		t_stop();
		t_modes();
		t_boot();
		close_out();
	end
endmodule
bind mmd_decoder mmd_decoder_properties mmd_decoder_properties_i (.ref_clk, .nrst, .stop_req, .cpu_valid,
	.cpu_vector, .cpu_addr, .mode_ready, .op_mode, .clk_run, .map_value, .rom_present_bit, .rom_placement_bit,
	.dec_valid, .sel_reg, .sel_ram, .sel_boot, .sel_rom, .sel_ext, .reg_offset, .ram_index, .boot_offset);
